// *** bench/fmo_field_model.sv ***
// Model of the override input wiring and operator keypad
`timescale 1ns/100ps
`default_nettype none
module fmo_field_model (
  input  wire logic ref_clk,
  input  wire logic open_req,
  input  wire logic press_req,
  output var logic  override_input_pin,
  output var logic  ack_key
);
  // Contact opening pulls the override input low
  always @(posedge ref_clk) begin
    override_input_pin <= ~open_req;
    ack_key            <= press_req;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the override controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fmo_pkg::*;
  localparam int DLY = 20;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic open_req = 1'b0;
  logic press_req = 1'b0;
  logic pin, ack, ar_sel = 1'b0, gen_req = 1'b0;
  logic run_cmd = 1'b0, gen_en = 1'b0, ov_f = 1'b0, oc_f = 1'b0;
  logic [2:0] cfg = 3'h0;
  logic [15:0] sref = 16'h1234, smax = 16'hFFF0, sout;
  logic alarm, ind, mrun, pen, cf, frp, hist;
  logic [3:0] code;
  logic act;
  int n_mismatch = 0;
  int num_checks = 0;
  int npulse;

  always #4 ref_clk = ~ref_clk;

  fmo_field_model i_fmo_field_model (.ref_clk(ref_clk), .open_req(open_req),
    .press_req(press_req), .override_input_pin(pin), .ack_key(ack));

  fmo_ctrl #(.DELAY_CYC(DLY)) i_fmo_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
    .override_input_pin(pin), .override_config_select(cfg),
    .override_autoreset_select(ar_sel), .general_autoreset_req(gen_req),
    .ack_key(ack), .run_cmd(run_cmd), .general_enable(gen_en),
    .speed_ref_in(sref), .max_speed_reference(smax),
    .dc_link_overvoltage_fault(ov_f), .output_overcurrent_fault(oc_f),
    .override_active_alarm(alarm), .drive_state_code(code),
    .override_indicator_output(ind), .motor_run(mrun), .pulse_enable(pen),
    .speed_ref_out(sout), .critical_fault(cf), .fault_reset_pulse(frp),
    .override_history(hist));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    tick(2);
    arst_n <= 1'b1;
    tick(2);
    // Every configuration, with run and enable removed
    for (int c = 0; c < 5; c++) begin
      cfg <= c[2:0];
      open_req <= 1'b1;
      tick(8);
      act = (c == 1 || c == 2 || c == 4);
      chk({15'h0, alarm}, {15'h0, act});
      chk({12'h0, code}, act ? {12'h0, FMO_STATE_OVERRIDE} : 16'h0000);
      chk({15'h0, ind}, {15'h0, act});
      if (act) begin
        chk(sout, (c == 2) ? smax : sref);
        chk({15'h0, pen}, (c == 4) ? 16'h0000 : 16'h0001);
        if (c != 4)
          chk({15'h0, mrun}, 16'h0001);
      end else begin
        chk({15'h0, mrun}, 16'h0000);
        chk({15'h0, pen}, 16'h0000);
        chk(sout, sref);
      end
      if (c == 1) begin
        press_req <= 1'b1;
        tick(6);
        press_req <= 1'b0;
        chk({15'h0, alarm}, 16'h0000);
        chk({12'h0, code}, {12'h0, FMO_STATE_OVERRIDE});
      end
      open_req <= 1'b0;
      tick(6);
      chk({12'h0, code}, 16'h0000);
      chk({15'h0, ind}, 16'h0000);
      chk({15'h0, mrun}, 16'h0000);
      chk({15'h0, pen}, 16'h0000);
      chk({15'h0, hist}, {15'h0, (c >= 1)});
    end
    // Critical faults under unlimited and limited auto-reset
    cfg <= FMO_CFG_ACTIVE;
    open_req <= 1'b1;
    ar_sel <= FMO_AR_UNLIMITED;
    ov_f <= 1'b1;
    tick(4);
    chk({15'h0, cf}, 16'h0001);
    npulse = 0;
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (frp === 1'b1)
        npulse++;
    end
    chk(npulse[15:0], 16'h0002);
    @(posedge ref_clk);
    ar_sel <= FMO_AR_LIMITED;
    ov_f <= 1'b0;
    oc_f <= 1'b1;
    tick(2);
    gen_req <= 1'b1;
    @(negedge ref_clk);
    chk({15'h0, frp}, 16'h0001);
    chk({15'h0, cf}, 16'h0001);
    @(posedge ref_clk);
    gen_req <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0, frp}, 16'h0000);
    test_done();
  end

  initial begin
    #(3000 * 8);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire

// *** src/fmo_ctrl.sv ***
// Emergency override supervisory controller
`timescale 1ns/100ps
`default_nettype none
module fmo_ctrl
  import fmo_pkg::*;
#(
  parameter int REF_W     = FMO_REF_W,
  parameter int DELAY_CYC = FMO_RESET_DELAY_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             override_input_pin,
  input  wire logic [2:0]       override_config_select,
  input  wire logic             override_autoreset_select,
  input  wire logic             general_autoreset_req,
  input  wire logic             ack_key,
  input  wire logic             run_cmd,
  input  wire logic             general_enable,
  input  wire logic [REF_W-1:0] speed_ref_in,
  input  wire logic [REF_W-1:0] max_speed_reference,
  input  wire logic             dc_link_overvoltage_fault,
  input  wire logic             output_overcurrent_fault,
  output logic                  override_active_alarm,
  output logic [3:0]            drive_state_code,
  output logic                  override_indicator_output,
  output logic                  motor_run,
  output logic                  pulse_enable,
  output logic [REF_W-1:0]      speed_ref_out,
  output logic                  critical_fault,
  output logic                  fault_reset_pulse,
  output logic                  override_history
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_reg;
  logic [1:0] ack_sync_reg;
  logic       ack_prev_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_reg <= 2'h3;
      ack_sync_reg <= 2'h0;
      ack_prev_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], override_input_pin};
      ack_sync_reg <= {ack_sync_reg[0], ack_key};
      ack_prev_reg <= ack_sync_reg[1];
    end
  end

  logic pin_low;
  logic ack_rise;
  logic cfg_valid;
  assign pin_low   = ~pin_sync_reg[1];
  assign ack_rise  = ack_sync_reg[1] & ~ack_prev_reg;
  // Only 1, 2 and 4 enable the function
  assign cfg_valid = (override_config_select == FMO_CFG_ACTIVE)
                   || (override_config_select == FMO_CFG_MAXREF)
                   || (override_config_select == FMO_CFG_COAST);

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  fmo_mode_e mode_reg;
  logic      active;
  assign active = (mode_reg == FMO_ACTIVE);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= FMO_IDLE;
    end else begin
      case (mode_reg)
        FMO_IDLE: begin
          if (pin_low && cfg_valid) begin
            mode_reg <= FMO_ACTIVE;
          end
        end
        FMO_ACTIVE: begin
          if (!pin_low || !cfg_valid) begin
            mode_reg <= FMO_IDLE;
          end
        end
        default: mode_reg <= FMO_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alarm, status code and history
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      override_active_alarm <= 1'b0;
    end else if (!active && pin_low && cfg_valid) begin
      override_active_alarm <= 1'b1;
    end else if (!active || ack_rise) begin
      override_active_alarm <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_state_code <= FMO_STATE_NORMAL;
    end else begin
      drive_state_code <= (!active && pin_low && cfg_valid) || (active && pin_low && cfg_valid)
                        ? FMO_STATE_OVERRIDE : FMO_STATE_NORMAL;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      override_history <= 1'b0;
    end else if (active) begin
      override_history <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Motor command outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      override_indicator_output <= 1'b0;
      motor_run                 <= 1'b0;
      pulse_enable              <= 1'b0;
      speed_ref_out             <= REF_W'(FMO_REF_RST);
    end else begin
      override_indicator_output <= active;
      if (active) begin
        motor_run    <= 1'b1;
        pulse_enable <= (override_config_select != FMO_CFG_COAST);
        speed_ref_out <= (override_config_select == FMO_CFG_MAXREF)
                       ? max_speed_reference : speed_ref_in;
      end else begin
        motor_run     <= run_cmd & general_enable;
        pulse_enable  <= run_cmd & general_enable;
        speed_ref_out <= speed_ref_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Critical faults stay active and use automatic reset
  // ----------------------------------------------------------------
  assign critical_fault = dc_link_overvoltage_fault | output_overcurrent_fault;

  fmo_fault_reset #(
    .DELAY_CYC(DELAY_CYC)
  ) u_reset (
    .ref_clk                  (ref_clk),
    .arst_n                   (arst_n),
    .override_active          (active),
    .override_autoreset_select(override_autoreset_select),
    .general_reset_req        (general_autoreset_req),
    .fault_present            (critical_fault),
    .fault_reset_pulse        (fault_reset_pulse)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_enter;
    @(posedge ref_clk) disable iff (!arst_n)
      (!active && pin_low && cfg_valid) |=> (active && override_active_alarm);
  endproperty
  a_enter: assert property (p_enter) else $error("override not entered");

  property p_code;
    @(posedge ref_clk) disable iff (!arst_n)
      active |-> (drive_state_code == FMO_STATE_OVERRIDE);
  endproperty
  a_code: assert property (p_code) else $error("state code wrong");

  property p_ack;
    @(posedge ref_clk) disable iff (!arst_n)
      (active && ack_rise && pin_low && cfg_valid) |=> (!override_active_alarm && active);
  endproperty
  a_ack: assert property (p_ack) else $error("ack failed");

  property p_ind;
    @(posedge ref_clk) disable iff (!arst_n)
      active |=> override_indicator_output;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator low");

  property p_stop;
    @(posedge ref_clk) disable iff (!arst_n)
      (active && !general_enable) |=> motor_run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop obeyed");

  property p_inactive;
    @(posedge ref_clk) disable iff (!arst_n)
      (override_config_select == FMO_CFG_INACTIVE || override_config_select == FMO_CFG_RESERVED)
      |=> !active;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive config entered");

  property p_maxref;
    @(posedge ref_clk) disable iff (!arst_n)
      (active && override_config_select == FMO_CFG_MAXREF) |=> (speed_ref_out == $past(max_speed_reference));
  endproperty
  a_maxref: assert property (p_maxref) else $error("max reference not forced");

  property p_coast;
    @(posedge ref_clk) disable iff (!arst_n)
      (active && override_config_select == FMO_CFG_COAST) |=> !pulse_enable;
  endproperty
  a_coast: assert property (p_coast) else $error("pulses not disabled");

  property p_hist;
    @(posedge ref_clk) disable iff (!arst_n)
      override_history |=> override_history;
  endproperty
  a_hist: assert property (p_hist) else $error("history lost");

  property p_exit;
    @(posedge ref_clk) disable iff (!arst_n)
      (active && !pin_low) |=> !active;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");

endmodule
`default_nettype wire

// *** src/fmo_fault_reset.sv ***
// Automatic reset of critical faults during override mode
`timescale 1ns/100ps
`default_nettype none
module fmo_fault_reset
  import fmo_pkg::*;
#(
  parameter int DELAY_CYC = FMO_RESET_DELAY_CYC
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic override_active,
  input  wire logic override_autoreset_select,
  input  wire logic general_reset_req,
  input  wire logic fault_present,
  output logic      fault_reset_pulse
);

  logic [31:0] cnt_reg;

  // ----------------------------------------------------------------
  // One-second delay after detection, repeated without limit
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 32'h0000_0000;
    end else if (!(override_active && override_autoreset_select) || !fault_present) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg >= 32'(DELAY_CYC - 1)) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // During override, unlimited mode ignores the general setting; limited mode and non-override operation defer to it
  assign fault_reset_pulse = (override_active && override_autoreset_select)
                           ? (fault_present && cnt_reg >= 32'(DELAY_CYC - 1))
                           : general_reset_req;

  property p_unl_delay;
    @(posedge ref_clk) disable iff (!arst_n)
      (override_active && override_autoreset_select && fault_present && cnt_reg == 32'h0)
      |-> !fault_reset_pulse;
  endproperty
  a_unl_delay: assert property (p_unl_delay) else $error("early unlimited reset");

  property p_limited;
    @(posedge ref_clk) disable iff (!arst_n)
      !override_autoreset_select |-> (fault_reset_pulse == general_reset_req);
  endproperty
  a_limited: assert property (p_limited) else $error("limited reset not general");

endmodule
`default_nettype wire

// *** src/fmo_pkg.sv ***
// Package of constants and types for the override controller
package fmo_pkg;

  // ----------------------------------------------------------------
  // Configuration encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] FMO_CFG_INACTIVE = 3'h0;
  localparam logic [2:0] FMO_CFG_ACTIVE   = 3'h1;
  localparam logic [2:0] FMO_CFG_MAXREF   = 3'h2;
  localparam logic [2:0] FMO_CFG_RESERVED = 3'h3;
  localparam logic [2:0] FMO_CFG_COAST    = 3'h4;

  localparam logic       FMO_AR_LIMITED   = 1'h0;
  localparam logic       FMO_AR_UNLIMITED = 1'h1;

  // ----------------------------------------------------------------
  // Status codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FMO_STATE_NORMAL   = 4'h0;
  localparam logic [3:0] FMO_STATE_OVERRIDE = 4'hA;
  localparam int         FMO_REF_W          = 16;
  localparam logic [15:0] FMO_REF_RST       = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FMO_CLK_MHZ          = 125;
  localparam int FMO_RESET_DELAY_MS   = 1000;
  localparam int FMO_RESET_DELAY_CYC  = FMO_RESET_DELAY_MS * 1000 * FMO_CLK_MHZ;

  typedef enum logic [1:0] {FMO_IDLE, FMO_ACTIVE} fmo_mode_e;

endpackage
